/* aesecb_pkg.sv */
// aesecb_pkg: register map, data structure layout and states of the codebook encryptor
// assumes: 32-bit Avalon-MM register bus with byte addresses, 32-bit word data RAM
package aesecb_pkg;

	localparam int ADDR_W = 12;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_START_TASK = 12'h000;
	localparam logic [ADDR_W-1:0] OFS_STOP_TASK  = 12'h004;
	localparam logic [ADDR_W-1:0] OFS_DONE_EVT   = 12'h100;
	localparam logic [ADDR_W-1:0] OFS_ERROR_EVT  = 12'h104;
	localparam logic [ADDR_W-1:0] OFS_IEN_SET    = 12'h304;
	localparam logic [ADDR_W-1:0] OFS_IEN_CLR    = 12'h308;
	localparam logic [ADDR_W-1:0] OFS_DATA_PTR   = 12'h504;

	// field positions
	localparam int BIT_TRIGGER = 0;
	localparam int BIT_EVENT   = 0;
	localparam int BIT_DONE    = 0;
	localparam int BIT_ERROR   = 1;
	localparam int NUM_EVENTS  = 2;

	// reset values
	localparam logic [31:0]           PTR_RESET  = 32'h0000_0000;
	localparam logic [NUM_EVENTS-1:0] EVT_RESET  = 2'h0;
	localparam logic [NUM_EVENTS-1:0] IEN_RESET  = 2'h0;
	localparam logic [31:0]           READ_ZERO  = 32'h0000_0000;

	// data structure layout in bytes, and as word indices
	localparam int KEY_BYTE    = 0;
	localparam int CLEAR_BYTE  = 16;
	localparam int CIPHER_BYTE = 32;
	localparam int BLOCK_BYTES = 16;
	localparam int WORD_BYTES  = 4;
	localparam int IDX_W       = 4;
	localparam logic [IDX_W-1:0] IDX_KEY      = IDX_W'(KEY_BYTE / WORD_BYTES);
	localparam logic [IDX_W-1:0] IDX_LAST_RD  = IDX_W'((CLEAR_BYTE + BLOCK_BYTES) / WORD_BYTES - 1);
	localparam logic [IDX_W-1:0] IDX_CIPHER   = IDX_W'(CIPHER_BYTE / WORD_BYTES);
	localparam logic [IDX_W-1:0] IDX_LAST_WR  = IDX_W'((CIPHER_BYTE + BLOCK_BYTES) / WORD_BYTES - 1);
	localparam int STRUCT_WORDS = (CIPHER_BYTE + BLOCK_BYTES) / WORD_BYTES;
	localparam int BLOCK_WORDS  = BLOCK_BYTES / WORD_BYTES;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_LOAD,
		ST_RUN,
		ST_STORE
	} aesecb_state_e;

endpackage : aesecb_pkg

/* aesecb_events.sv */
// aesecb_events: sticky event flags, interrupt enables and the level interrupt
// assumes: one clock, synchronous active-high reset, clock enable from the parent
`timescale 1ns/1ps
module aesecb_events #(
	parameter int N = aesecb_pkg::NUM_EVENTS
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	input  wire logic         i_ce,
	input  wire logic [N-1:0] i_hw_set,
	input  wire logic [N-1:0] i_sw_wr,
	input  wire logic [N-1:0] i_sw_wdata,
	input  wire logic [N-1:0] i_en_set,
	input  wire logic [N-1:0] i_en_clr,
	output logic      [N-1:0] o_flags,
	output logic      [N-1:0] o_enables,
	output logic              o_irq
);

	logic [N-1:0] flags_r;
	logic [N-1:0] en_r;

	// software write stores its value, hardware set wins the same cycle
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			flags_r <= aesecb_pkg::EVT_RESET;
		else if (i_ce)
			flags_r <= (flags_r & ~i_sw_wr) | (i_sw_wr & i_sw_wdata) | i_hw_set;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			en_r <= aesecb_pkg::IEN_RESET;
		else if (i_ce)
			en_r <= (en_r | i_en_set) & ~i_en_clr;
	end

	assign o_flags   = flags_r;
	assign o_enables = en_r;
	assign o_irq     = |(flags_r & en_r);

	////////////////////////////////////////////////////////////////////////////////

	property p_en_set;
		@(posedge i_clk) disable iff (i_rst)
		(i_ce && i_en_set[0] && !i_en_clr[0]) |=> o_enables[0];
	endproperty
	a_en_set: assert property (p_en_set) else $error("enable set lost");

	property p_en_clr;
		@(posedge i_clk) disable iff (i_rst)
		(i_ce && i_en_clr[1]) |=> !o_enables[1];
	endproperty
	a_en_clr: assert property (p_en_clr) else $error("enable clear lost");

	property p_flag_sticky;
		@(posedge i_clk) disable iff (i_rst)
		(o_flags[0] && !(i_ce && i_sw_wr[0] && !i_sw_wdata[0])) |=> o_flags[0];
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped");

	property p_irq_rise;
		@(posedge i_clk) disable iff (i_rst)
		(i_ce && i_hw_set[1] && o_enables[1] && !i_en_clr[1]) |=> o_irq;
	endproperty
	a_irq_rise: assert property (p_irq_rise) else $error("irq not raised");

endmodule : aesecb_events

/* aesecb_top.sv */
// aesecb_top: control of single-block codebook encryption, register slave and data mover
// assumes: Avalon-MM slave with waitrequest; RAM port holds req until a one-cycle ack;
// shared AES core reports busy, preempt and done; i_ce also gates the RAM and the core
//
// How it works
// - a start while the shared AES core is busy starts nothing and raises the error event.
// - a stop during a running encryption aborts it and raises the error event.
// - the completion flag becomes 1 when an encryption finishes and holds until software writes it.
// - the error flag becomes 1 whenever an encryption is abandoned by stop or error.
// - writing one to the completion bit of enable-set enables it; reads give the enable.
// - writing one to the error bit of enable-set enables it; writing zero changes nothing.
// - writing one to the completion bit of enable-clear disables it; reads give the enable.
// - writing one to the error bit of enable-clear disables it; reads give the enable.
// - software loads the data pointer, and every RAM access is based on it.
// - the key sits at byte 0, cleartext at byte 16 and ciphertext at byte 32.
// - start fetches key and cleartext, completion follows the ciphertext write-back.
// - this block yields the core to others and aborts with an error on a conflict.
// - no RAM access is outstanding when the completion or error event is raised.
//
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
module aesecb_top (
	input  wire logic                           i_clk,
	input  wire logic                           i_rst,
	input  wire logic                           i_ce,
	input  wire logic [aesecb_pkg::ADDR_W-1:0]  i_avs_address,
	input  wire logic                           i_avs_read,
	input  wire logic                           i_avs_write,
	input  wire logic [31:0]                    i_avs_writedata,
	input  wire logic [3:0]                     i_avs_byteenable,
	output logic      [31:0]                    o_avs_readdata,
	output logic                                o_avs_waitrequest,
	input  wire logic                           i_hw_start,
	input  wire logic                           i_hw_stop,
	output logic                                o_dma_req,
	output logic                                o_dma_we,
	output logic      [31:0]                    o_dma_addr,
	output logic      [31:0]                    o_dma_wdata,
	input  wire logic                           i_dma_ack,
	input  wire logic [31:0]                    i_dma_rdata,
	input  wire logic                           i_aes_busy,
	input  wire logic                           i_aes_preempt,
	output logic                                o_aes_start,
	output logic                                o_aes_claim,
	output logic      [127:0]                   o_aes_key,
	output logic      [127:0]                   o_aes_block,
	input  wire logic                           i_aes_done,
	input  wire logic [127:0]                   i_aes_result,
	output logic                                o_done_pulse,
	output logic                                o_error_pulse,
	output logic                                o_busy,
	output logic                                o_irq
);

	localparam int NE = aesecb_pkg::NUM_EVENTS;
	localparam int IW = aesecb_pkg::IDX_W;
	// byte address of a structure word
	function automatic logic [31:0] word_addr(input logic [31:0] base, input logic [IW-1:0] idx);
		word_addr = base + {26'h0, idx, 2'h0};
	endfunction : word_addr

	aesecb_pkg::aesecb_state_e st_r;
	logic [IW-1:0] idx_r;
	logic          abort_r;
	logic          served_r;
	logic [31:0]   ptr_r;
	logic [31:0]   rdata_r;
	logic          aes_start_r;
	logic [31:0]   words_r [aesecb_pkg::STRUCT_WORDS];
	logic          done_pulse_r;
	logic          error_pulse_r;

	logic          wr_go;
	logic          sw_start;
	logic          sw_stop;
	logic          start_trig;
	logic          stop_trig;
	logic          abort_now;
	logic          done_set;
	logic          err_set;
	logic [NE-1:0] flags;
	logic [NE-1:0] enables;
	logic [NE-1:0] flag_wr;
	logic [NE-1:0] en_set;
	logic [NE-1:0] en_clr;
	logic [31:0]   rd_mux;

	////////////////////////////////////////////////////////////////////////////////
	// register slave: every access answers on its second edge
	assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~served_r;
	assign wr_go = i_ce & i_avs_write & served_r & i_avs_byteenable[0];

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			served_r <= 1'b0;
		else if (i_ce)
			served_r <= (i_avs_read | i_avs_write) & ~served_r;
	end

	assign sw_start   = wr_go && i_avs_address == aesecb_pkg::OFS_START_TASK
		&& i_avs_writedata[aesecb_pkg::BIT_TRIGGER];
	assign sw_stop    = wr_go && i_avs_address == aesecb_pkg::OFS_STOP_TASK
		&& i_avs_writedata[aesecb_pkg::BIT_TRIGGER];
	assign start_trig = sw_start | (i_ce & i_hw_start);
	assign stop_trig  = sw_stop | (i_ce & i_hw_stop);

	assign flag_wr[aesecb_pkg::BIT_DONE]  = wr_go && i_avs_address == aesecb_pkg::OFS_DONE_EVT;
	assign flag_wr[aesecb_pkg::BIT_ERROR] = wr_go && i_avs_address == aesecb_pkg::OFS_ERROR_EVT;
	assign en_set = (wr_go && i_avs_address == aesecb_pkg::OFS_IEN_SET)
		? i_avs_writedata[NE-1:0] : '0;
	assign en_clr = (wr_go && i_avs_address == aesecb_pkg::OFS_IEN_CLR)
		? i_avs_writedata[NE-1:0] : '0;

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			ptr_r <= aesecb_pkg::PTR_RESET;
		else if (i_ce && i_avs_write && served_r && i_avs_address == aesecb_pkg::OFS_DATA_PTR)
		begin
			for (int b = 0; b < 4; b++)
				if (i_avs_byteenable[b])
					ptr_r[8*b +: 8] <= i_avs_writedata[8*b +: 8];
		end
	end

	// tasks and unmapped offsets read zero
	always_comb
	begin
		rd_mux = aesecb_pkg::READ_ZERO;
		case (i_avs_address)
			aesecb_pkg::OFS_DONE_EVT:
				rd_mux[aesecb_pkg::BIT_EVENT] = flags[aesecb_pkg::BIT_DONE];
			aesecb_pkg::OFS_ERROR_EVT:
				rd_mux[aesecb_pkg::BIT_EVENT] = flags[aesecb_pkg::BIT_ERROR];
			aesecb_pkg::OFS_IEN_SET,
			aesecb_pkg::OFS_IEN_CLR:
				rd_mux[NE-1:0] = enables;
			aesecb_pkg::OFS_DATA_PTR:
				rd_mux = ptr_r;
			default:
				rd_mux = aesecb_pkg::READ_ZERO;
		endcase
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			rdata_r <= aesecb_pkg::READ_ZERO;
		else if (i_ce && i_avs_read && !served_r)
			rdata_r <= rd_mux;
	end

	assign o_avs_readdata = rdata_r;

	////////////////////////////////////////////////////////////////////////////////
	// event sources
	assign abort_now = abort_r | stop_trig;
	assign done_set  = st_r == aesecb_pkg::ST_STORE && i_dma_ack && !abort_now
		&& idx_r == aesecb_pkg::IDX_LAST_WR;
	assign err_set   = (st_r == aesecb_pkg::ST_IDLE && start_trig && i_aes_busy)
		|| ((st_r == aesecb_pkg::ST_LOAD || st_r == aesecb_pkg::ST_STORE)
			&& i_dma_ack && abort_now)
		|| (st_r == aesecb_pkg::ST_LOAD && i_dma_ack && !abort_now
			&& idx_r == aesecb_pkg::IDX_LAST_RD && i_aes_busy)
		|| (st_r == aesecb_pkg::ST_RUN && (stop_trig || i_aes_preempt));

	aesecb_events #(
		.N (NE)
	) u_events (
		.i_clk      (i_clk),
		.i_rst      (i_rst),
		.i_ce       (i_ce),
		.i_hw_set   ({i_ce & err_set, i_ce & done_set}),
		.i_sw_wr    (flag_wr),
		.i_sw_wdata ({2{i_avs_writedata[aesecb_pkg::BIT_EVENT]}}),
		.i_en_set   (en_set),
		.i_en_clr   (en_clr),
		.o_flags    (flags),
		.o_enables  (enables),
		.o_irq      (o_irq)
	);

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			done_pulse_r  <= 1'b0;
			error_pulse_r <= 1'b0;
		end
		else if (i_ce)
		begin
			done_pulse_r  <= done_set;
			error_pulse_r <= err_set;
		end
	end

	assign o_done_pulse  = done_pulse_r;
	assign o_error_pulse = error_pulse_r;
	////////////////////////////////////////////////////////////////////////////////
	// sequencer: load key and cleartext, encrypt, store ciphertext
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			st_r    <= aesecb_pkg::ST_IDLE;
			idx_r   <= aesecb_pkg::IDX_KEY;
			abort_r <= 1'b0;
		end
		else if (i_ce)
		begin
			case (st_r)
				aesecb_pkg::ST_IDLE:
				begin
					abort_r <= 1'b0;
					idx_r   <= aesecb_pkg::IDX_KEY;
					if (start_trig && !i_aes_busy)
						st_r <= aesecb_pkg::ST_LOAD;
				end
				aesecb_pkg::ST_LOAD:
				begin
					if (!i_dma_ack)
						abort_r <= abort_now;
					else if (abort_now || (idx_r == aesecb_pkg::IDX_LAST_RD && i_aes_busy))
						st_r <= aesecb_pkg::ST_IDLE;
					else if (idx_r == aesecb_pkg::IDX_LAST_RD)
						st_r <= aesecb_pkg::ST_RUN;
					else
						idx_r <= idx_r + 1'b1;
				end
				aesecb_pkg::ST_RUN:
				begin
					if (stop_trig || i_aes_preempt)
						st_r <= aesecb_pkg::ST_IDLE;
					else if (i_aes_done)
					begin
						st_r  <= aesecb_pkg::ST_STORE;
						idx_r <= aesecb_pkg::IDX_CIPHER;
					end
				end
				aesecb_pkg::ST_STORE:
				begin
					if (!i_dma_ack)
						abort_r <= abort_now;
					else if (abort_now || idx_r == aesecb_pkg::IDX_LAST_WR)
						st_r <= aesecb_pkg::ST_IDLE;
					else
						idx_r <= idx_r + 1'b1;
				end
				default:
					st_r <= aesecb_pkg::ST_IDLE;
			endcase
		end
	end

	// structure words: key, cleartext, then ciphertext
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			for (int w = 0; w < aesecb_pkg::STRUCT_WORDS; w++)
				words_r[w] <= aesecb_pkg::READ_ZERO;
		end
		else if (i_ce)
		begin
			if (st_r == aesecb_pkg::ST_LOAD && i_dma_ack)
				words_r[idx_r] <= i_dma_rdata;
			else if (st_r == aesecb_pkg::ST_RUN && i_aes_done)
			begin
				for (int k = 0; k < aesecb_pkg::BLOCK_WORDS; k++)
					words_r[aesecb_pkg::IDX_CIPHER + k] <= i_aes_result[127 - 32*k -: 32];
			end
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			aes_start_r <= 1'b0;
		else if (i_ce)
			aes_start_r <= st_r == aesecb_pkg::ST_LOAD && i_dma_ack && !abort_now
				&& idx_r == aesecb_pkg::IDX_LAST_RD && !i_aes_busy;
	end
	assign o_aes_start = aes_start_r;
	assign o_aes_claim = st_r == aesecb_pkg::ST_RUN;
	assign o_aes_key   = {words_r[0], words_r[1], words_r[2], words_r[3]};
	assign o_aes_block = {words_r[4], words_r[5], words_r[6], words_r[7]};
	assign o_dma_req   = st_r == aesecb_pkg::ST_LOAD || st_r == aesecb_pkg::ST_STORE;
	assign o_dma_we    = st_r == aesecb_pkg::ST_STORE;
	assign o_dma_addr  = word_addr(ptr_r, idx_r);
	assign o_dma_wdata = words_r[idx_r];
	assign o_busy      = st_r != aesecb_pkg::ST_IDLE;
	////////////////////////////////////////////////////////////////////////////////
	property p_busy_start;
		@(posedge i_clk) disable iff (i_rst)
		(i_ce && start_trig && st_r == aesecb_pkg::ST_IDLE && i_aes_busy)
			|=> (st_r == aesecb_pkg::ST_IDLE && o_error_pulse && flags[1]);
	endproperty
	a_busy_start: assert property (p_busy_start) else $error("busy start not refused");
	property p_stop_run;
		@(posedge i_clk) disable iff (i_rst)
		(i_ce && stop_trig && st_r == aesecb_pkg::ST_RUN) |=> (!o_busy && o_error_pulse);
	endproperty
	a_stop_run: assert property (p_stop_run) else $error("stop did not abort");
	property p_done_flag;
		@(posedge i_clk) disable iff (i_rst)
		(i_ce && done_set) |=> (flags[0] && !o_busy && o_done_pulse);
	endproperty
	a_done_flag: assert property (p_done_flag) else $error("done flag not set");
	property p_preempt;
		@(posedge i_clk) disable iff (i_rst)
		(i_ce && o_aes_claim && i_aes_preempt) |=> (flags[1] && !o_aes_claim);
	endproperty
	a_preempt: assert property (p_preempt) else $error("conflict not aborted");
	property p_event_quiet;
		@(posedge i_clk) disable iff (i_rst)
		(i_ce && (done_set || err_set)) |=> !o_dma_req;
	endproperty
	a_event_quiet: assert property (p_event_quiet) else $error("ram access after event");
	property p_store_area;
		@(posedge i_clk) disable iff (i_rst)
		(o_dma_req && o_dma_we) |-> (o_dma_addr - ptr_r >= 32'(aesecb_pkg::CIPHER_BYTE));
	endproperty
	a_store_area: assert property (p_store_area) else $error("write outside cipher area");
	property p_task_reads_zero;
		@(posedge i_clk) disable iff (i_rst)
		(i_ce && i_avs_read && !served_r && i_avs_address == aesecb_pkg::OFS_STOP_TASK)
			|=> (o_avs_readdata == aesecb_pkg::READ_ZERO && !o_avs_waitrequest);
	endproperty
	a_task_reads_zero: assert property (p_task_reads_zero) else $error("task read not zero");
	property p_load_to_run;
		@(posedge i_clk) disable iff (i_rst)
		$rose(o_aes_claim) |-> $past(o_dma_req) && !o_dma_req;
	endproperty
	a_load_to_run: assert property (p_load_to_run) else $error("run began without load");

endmodule : aesecb_top

/* aesecb_far_model.sv */
// aesecb_far_model: data RAM and shared AES core as seen from the encryptor
// assumes: one clock, RAM word index taken from address bits 9:2
`timescale 1ns/1ps
module aesecb_far_model #(
	parameter int CORE_CYCLES = 16
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	input  wire logic [3:0]   i_delay,
	input  wire logic         i_dma_req,
	input  wire logic         i_dma_we,
	input  wire logic [31:0]  i_dma_addr,
	input  wire logic [31:0]  i_dma_wdata,
	output logic              o_dma_ack,
	output logic      [31:0]  o_dma_rdata,
	input  wire logic         i_aes_start,
	input  wire logic [127:0] i_aes_key,
	input  wire logic [127:0] i_aes_block,
	output logic              o_aes_done,
	output logic      [127:0] o_aes_result
);
	logic [31:0]  mem_r [256];
	logic [31:0]  rd_r;
	logic [3:0]   wait_r;
	logic [127:0] res_r;
	int           run_r;

	initial
	begin
		for (int i = 0; i < 256; i++)
			mem_r[i] = 32'hC0DE0000 ^ (i * 32'h00010003);
	end

	// one beat per request, acked after i_delay idle cycles
	always @(posedge i_clk)
	begin
		o_dma_ack <= 1'h0;
		if (i_rst)
			wait_r <= 4'h0;
		else if (i_dma_req && !o_dma_ack)
		begin
			if (wait_r >= i_delay)
			begin
				o_dma_ack <= 1'h1;
				wait_r    <= 4'h0;
				if (i_dma_we)
					mem_r[i_dma_addr[9:2]] <= i_dma_wdata;
				else
					rd_r <= mem_r[i_dma_addr[9:2]];
			end
			else
				wait_r <= wait_r + 4'h1;
		end
	end

	// data lines show no stale value outside an ack
	assign o_dma_rdata  = o_dma_ack ? rd_r : ~rd_r;
	assign o_aes_result = o_aes_done ? res_r : ~res_r;

	always @(posedge i_clk)
	begin
		o_aes_done <= !i_rst && run_r == 1;
		if (i_rst)
			run_r <= 0;
		else if (i_aes_start)
		begin
			res_r <= i_aes_key ^ i_aes_block;
			run_r <= CORE_CYCLES;
		end
		else if (run_r > 0)
			run_r <= run_r - 1;
	end
endmodule : aesecb_far_model

/* aesecb_tb_top.sv */
// aesecb_tb_top: register-level tests of the codebook encryptor
// assumes: far model holds RAM at word 0x80 onward as the data structure
`timescale 1ns/1ps
module aesecb_tb_top;
	localparam int PW = 32'h80;
	logic         i_clk = 1'h0;
	logic         i_rst = 1'h1;
	logic [11:0]  i_avs_address = 12'h000;
	logic         i_avs_read = 1'h0;
	logic         i_avs_write = 1'h0;
	logic [31:0]  i_avs_writedata = 32'h0;
	logic [3:0]   i_avs_byteenable = 4'hF;
	logic         i_hw_start = 1'h0;
	logic         i_hw_stop = 1'h0;
	logic         i_aes_busy = 1'h0;
	logic         i_aes_preempt = 1'h0;
	logic [3:0]   delay = 4'h0;
	logic [31:0]  o_avs_readdata, o_dma_addr, o_dma_wdata, i_dma_rdata, q;
	logic         o_avs_waitrequest, o_dma_req, o_dma_we, i_dma_ack, o_aes_start;
	logic         o_aes_claim, i_aes_done, o_done_pulse, o_error_pulse, o_busy, o_irq;
	logic [127:0] o_aes_key, o_aes_block, i_aes_result;
	logic [11:0]  regs [8] = '{12'h000, 12'h004, 12'h100, 12'h104, 12'h304, 12'h308,
		12'h504, 12'h200};
	int           num_errors = 0;
	int           total_checks = 0;
	int           beats = 0;
	int           dones = 0;
	int           errs = 0;
	int           b0;

	aesecb_top uut (.i_clk(i_clk), .i_rst(i_rst), .i_ce(1'h1),
		.i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
		.i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
		.o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
		.i_hw_start(i_hw_start), .i_hw_stop(i_hw_stop), .o_dma_req(o_dma_req),
		.o_dma_we(o_dma_we), .o_dma_addr(o_dma_addr), .o_dma_wdata(o_dma_wdata),
		.i_dma_ack(i_dma_ack), .i_dma_rdata(i_dma_rdata), .i_aes_busy(i_aes_busy),
		.i_aes_preempt(i_aes_preempt), .o_aes_start(o_aes_start), .o_aes_claim(o_aes_claim),
		.o_aes_key(o_aes_key), .o_aes_block(o_aes_block), .i_aes_done(i_aes_done),
		.i_aes_result(i_aes_result), .o_done_pulse(o_done_pulse),
		.o_error_pulse(o_error_pulse), .o_busy(o_busy), .o_irq(o_irq));

	aesecb_far_model far (.i_clk(i_clk), .i_rst(i_rst), .i_delay(delay),
		.i_dma_req(o_dma_req), .i_dma_we(o_dma_we), .i_dma_addr(o_dma_addr),
		.i_dma_wdata(o_dma_wdata), .o_dma_ack(i_dma_ack), .o_dma_rdata(i_dma_rdata),
		.i_aes_start(o_aes_start), .i_aes_key(o_aes_key), .i_aes_block(o_aes_block),
		.o_aes_done(i_aes_done), .o_aes_result(i_aes_result));

	always #5 i_clk = ~i_clk;

	////////////////////////////////////////////////////////////////////////////////
	function automatic void chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endfunction : chk

	always @(posedge i_clk)
	begin
		if (o_dma_req === 1'h1 && i_dma_ack === 1'h1)
			beats <= beats + 1;
		if (o_done_pulse === 1'h1)
			dones <= dones + 1;
		if (o_error_pulse === 1'h1)
			errs <= errs + 1;
		if ((o_done_pulse | o_error_pulse) === 1'h1)
			chk(32'(o_dma_req), 32'h0);
	end

	task automatic bus(input logic we, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge i_clk);
		i_avs_address   <= a;
		i_avs_write     <= we;
		i_avs_read      <= ~we;
		i_avs_writedata <= d;
		do
		begin
			@(posedge i_clk);
			n++;
		end
		while (o_avs_waitrequest !== 1'h0 && n < 50);
		q = o_avs_readdata;
		if (n >= 50)
			chk(32'h0, 32'h1);
		i_avs_read  <= 1'h0;
		i_avs_write <= 1'h0;
	endtask : bus

	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		bus(1'h0, a, 32'h0);
		chk(q, exp);
	endtask : rd

	// read an event flag until it shows set
	task automatic poll(input logic [11:0] a);
		int n;
		n = 0;
		do
		begin
			bus(1'h0, a, 32'h0);
			n++;
		end
		while (q !== 32'h1 && n < 100);
		chk(q, 32'h1);
	endtask : poll

	task automatic strobe(input logic [2:0] m);
		@(posedge i_clk);
		{i_hw_start, i_hw_stop, i_aes_preempt} <= m;
		@(posedge i_clk);
		{i_hw_start, i_hw_stop, i_aes_preempt} <= 3'h0;
	endtask : strobe

	task automatic wait_claim;
		int n;
		n = 0;
		do
		begin
			@(posedge i_clk);
			n++;
		end
		while (o_aes_claim !== 1'h1 && n < 100);
	endtask : wait_claim

	task automatic clr_flags;
		bus(1'h1, 12'h100, 32'h0);
		bus(1'h1, 12'h104, 32'h0);
	endtask : clr_flags

	task automatic test_end(input string s);
		$display("test %s finished", s);
	endtask : test_end

	task automatic report_and_stop;
		$display("checks %0d, mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : report_and_stop

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (20) @(posedge i_clk);
		i_rst <= 1'h0;
		bus(1'h1, 12'h200, 32'hFFFFFFFF);
		foreach (regs[i])
			rd(regs[i], 32'h0);
		test_end("reset");
		bus(1'h1, 12'h504, 32'h200);
		rd(12'h504, 32'h200);
		i_avs_byteenable <= 4'h1;
		bus(1'h1, 12'h504, 32'hFFFFFF00);
		i_avs_byteenable <= 4'hF;
		rd(12'h504, 32'h200);
		bus(1'h1, 12'h304, 32'h3);
		bus(1'h1, 12'h304, 32'h0);
		rd(12'h304, 32'h3);
		rd(12'h308, 32'h3);
		bus(1'h1, 12'h000, 32'h0);
		repeat (4) @(posedge i_clk);
		chk(32'(beats), 32'h0);
		test_end("enables");
		bus(1'h1, 12'h000, 32'h1);
		poll(12'h100);
		chk(32'(beats), 32'hC);
		for (int i = 0; i < 4; i++)
		begin
			chk(far.mem_r[PW+8+i], far.mem_r[PW+i] ^ far.mem_r[PW+4+i]);
			chk(o_aes_key[127-32*i -: 32], far.mem_r[PW+i]);
			chk(o_aes_block[127-32*i -: 32], far.mem_r[PW+4+i]);
		end
		rd(12'h104, 32'h0);
		chk(32'(o_irq), 32'h1);
		bus(1'h1, 12'h308, 32'h1);
		rd(12'h304, 32'h2);
		chk(32'(o_irq), 32'h0);
		rd(12'h100, 32'h1);
		clr_flags();
		rd(12'h100, 32'h0);
		bus(1'h1, 12'h308, 32'h2);
		rd(12'h308, 32'h0);
		bus(1'h1, 12'h304, 32'h2);
		test_end("encrypt");
		i_aes_busy <= 1'h1;
		b0 = beats;
		bus(1'h1, 12'h000, 32'h1);
		poll(12'h104);
		chk(32'(beats - b0), 32'h0);
		chk(32'(o_irq), 32'h1);
		i_aes_busy <= 1'h0;
		clr_flags();
		@(posedge i_clk);
		chk(32'(o_irq), 32'h0);
		test_end("busy core");
		// software stop in run, hardware stop in load, preempt in run
		for (int k = 0; k < 3; k++)
		begin
			delay <= (k == 1) ? 4'h6 : 4'h0;
			if (k == 0)
				bus(1'h1, 12'h000, 32'h1);
			else
				strobe(3'h4);
			if (k == 1)
				repeat (3) @(posedge i_clk);
			else
				wait_claim();
			if (k == 0)
				bus(1'h1, 12'h004, 32'h1);
			else
				strobe((k == 1) ? 3'h2 : 3'h1);
			poll(12'h104);
			rd(12'h100, 32'h0);
			chk(32'(o_busy), 32'h0);
			clr_flags();
		end
		test_end("aborts");
		strobe(3'h4);
		poll(12'h100);
		test_end("hardware start");
		chk(32'(dones), 32'h2);
		chk(32'(errs), 32'h4);
		report_and_stop();
	end

	initial
	begin
		repeat (20000) @(posedge i_clk);
		num_errors++;
		report_and_stop();
	end
endmodule : aesecb_tb_top
